// ### rxen_map.svh
/*
  Offsets, field positions, reset values and fixed codes of the
  receiver-enable mask and exception flag register group.
  Assumes an 8-bit register space addressed by a 12-bit offset.
*/
`ifndef RXEN_MAP_SVH
`define RXEN_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_FRAME_CTRL    12'h00d
`define OFS_MASK_LO       12'h00e
`define OFS_MASK_HI       12'h00f
`define OFS_EXC_LO        12'h010

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FRAME_CTRL_RESET  3'h1
`define MASK_RESET        16'h0000
`define EXC_RESET         8'h00

// ------------------------------------------------------------
// receiver-enable mask bits touched by strobes
// ------------------------------------------------------------
`define MASK_BIT_RX_ON    15
`define MASK_BIT_TX_ON    14
`define MASK_BIT_STB13    13

// ------------------------------------------------------------
// exception flag positions, low byte
// ------------------------------------------------------------
`define EXC_RADIO_IDLE    0
`define EXC_FRAME_SENT    1
`define EXC_ACK_SENT      2
`define EXC_TX_UNDER      3
`define EXC_TX_OVER       4
`define EXC_RX_UNDER      5
`define EXC_RX_OVER       6
`define EXC_MASK_ZERO     7

// byte sent in place of a missing one while starvation is ignored
`define TX_FILL_BYTE      8'h00

`endif

// ### rxen_pkg.sv
/*
  Types of the receiver-enable mask block: register state and the
  transmit byte pump state.
  Assumes rxen_map.svh for the numeric constants.
*/
`default_nettype none

package rxen_pkg;

  typedef struct packed {
    logic pend_ovr;
    logic starve_ign;
    logic tx_sets;
  } frame_ctrl_t;

  typedef struct packed {
    frame_ctrl_t fc;
    logic [15:0] mask;
    logic [7:0]  flags;
    logic [7:0]  rdata;
    logic        ack_pend;
    logic        rx_auto_on;
  } top_state_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_phase_t;

  typedef struct packed {
    tx_phase_t   phase;
    logic [6:0]  left;
    logic [7:0]  data;
    logic        valid;
    logic        pop;
    logic        starve;
    logic        abort;
    logic        done;
  } tx_state_t;

endpackage

`default_nettype wire

// ### mask_upd_if.sv
/*
  Update requests for the receiver-enable mask, carried from the
  register block to the merge logic and the merged result back.
  Assumes all signals are single-cycle, sampled on the system clock.
*/
`default_nettype none

interface mask_upd_if;
  logic        rf_off;
  logic        tx_on;
  logic        tx_sets;
  logic        rx_on;
  logic        m_or;
  logic        m_and;
  logic        b13_set;
  logic        b13_clr;
  logic [15:0] operand;
  logic [15:0] bus_we;
  logic [15:0] bus_val;
  logic [15:0] cur;
  logic [15:0] nxt;

  modport ctrl (output rf_off, tx_on, tx_sets, rx_on, m_or, m_and, b13_set, b13_clr,
                output operand, bus_we, bus_val, cur, input nxt);
  modport merge (input rf_off, tx_on, tx_sets, rx_on, m_or, m_and, b13_set, b13_clr,
                 input operand, bus_we, bus_val, cur, output nxt);
endinterface

`default_nettype wire

// ### mask_merge.sv
/*
  Combinational merge of all concurrent update requests to the
  receiver-enable mask.
  Assumes the caller registers the result and holds it while frozen.
*/
`default_nettype none
`include "rxen_map.svh"

module mask_merge (
  mask_upd_if.merge mu
);

  logic [15:0] m;

  // sources are applied lowest priority first, so a later one wins
  // only on the bits it actually touches
  always_comb
  begin
    m = mu.cur;
    if (mu.b13_clr)
      m[`MASK_BIT_STB13] = 1'b0;
    if (mu.b13_set)
      m[`MASK_BIT_STB13] = 1'b1;
    if (mu.m_and)
      m = m & mu.operand;
    if (mu.m_or)
      m = m | mu.operand;
    if (mu.rx_on)
      m[`MASK_BIT_RX_ON] = 1'b1;
    if (mu.tx_on && mu.tx_sets)
      m[`MASK_BIT_TX_ON] = 1'b1;
    if (mu.rf_off)
      m = 16'h0000;
    m = (m & ~mu.bus_we) | (mu.bus_val & mu.bus_we);
    mu.nxt = m;
  end

endmodule // mask_merge

`default_nettype wire

// ### tx_starve.sv
/*
  Transmit byte pump: counts out the frame length and handles an
  empty transmit buffer either by aborting or by sending fill bytes.
  Assumes the modulator asks for one byte per request pulse.
*/
`default_nettype none
`include "rxen_map.svh"

module tx_starve (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [6:0] len,
  input  wire logic       byte_req,
  input  wire logic       fifo_empty,
  input  wire logic [7:0] fifo_byte,
  input  wire logic       ignore,
  output var  logic [7:0] out_byte,
  output var  logic       out_valid,
  output var  logic       pop,
  output var  logic       starve,
  output var  logic       abort,
  output var  logic       done
);

  rxen_pkg::tx_state_t st_r, st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    st_nxt.pop = 1'b0;
    st_nxt.starve = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.done = 1'b0;
    unique case (st_r.phase)
      rxen_pkg::TX_IDLE:
      begin
        if (start && len == 7'h00)
          st_nxt.done = 1'b1;
        else if (start)
        begin
          st_nxt.phase = rxen_pkg::TX_SEND;
          st_nxt.left = len;
        end
      end
      rxen_pkg::TX_SEND:
      begin
        if (byte_req && fifo_empty)
        begin
          st_nxt.starve = 1'b1;
          if (!ignore)
          begin
            st_nxt.abort = 1'b1;
            st_nxt.phase = rxen_pkg::TX_IDLE;
          end
          else
          begin
            st_nxt.valid = 1'b1;
            st_nxt.data = `TX_FILL_BYTE;
          end
        end
        else if (byte_req)
        begin
          st_nxt.valid = 1'b1;
          st_nxt.pop = 1'b1;
          st_nxt.data = fifo_byte;
        end
        // the length count ends the frame unless a starvation abort has ended it first
        if (st_nxt.valid)
        begin
          st_nxt.left = st_r.left - 7'h01;
          if (st_r.left == 7'h01)
          begin
            st_nxt.done = 1'b1;
            st_nxt.phase = rxen_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (!ce)
      st_nxt = st_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign out_byte = st_r.data;
  assign out_valid = st_r.valid;
  assign pop = st_r.pop;
  assign starve = st_r.starve;
  assign abort = st_r.abort;
  assign done = st_r.done;

  property p_starve_abort;
    @(posedge clk) disable iff (rst)
    (ce && st_r.phase == rxen_pkg::TX_SEND && byte_req && fifo_empty && !ignore) |=> (abort && starve && !out_valid);
  endproperty
  a_starve_abort: assert property (p_starve_abort) else $error("underflow did not abort");

  property p_starve_fill;
    @(posedge clk) disable iff (rst)
    (ce && st_r.phase == rxen_pkg::TX_SEND && byte_req && fifo_empty && ignore) |=> (!abort && starve && out_valid);
  endproperty
  a_starve_fill: assert property (p_starve_fill) else $error("ignored underflow broke frame");

  c_abort: cover property (@(posedge clk) disable iff (rst) abort);

endmodule // tx_starve

`default_nettype wire

// ### rx_enable_ctrl.sv
/*
  Frame-handling control byte, 16-bit receiver-enable mask and low
  exception flag byte of the radio transceiver, with the transmit
  starvation handling that the control byte steers.
  Assumes the serial command decoder presents register accesses,
  bit instructions, strobes and mask instructions as one-cycle
  pulses synchronous to CLK_SYS.
*/
`default_nettype none
`include "rxen_map.svh"

module rx_enable_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        BIT_SET,
  input  wire logic        BIT_CLR,
  input  wire logic [11:0] BIT_ADDR,
  input  wire logic [2:0]  BIT_IDX,
  input  wire logic        TX_ON_STB,
  input  wire logic        RX_ON_STB,
  input  wire logic        RF_OFF_STB,
  input  wire logic        MASK_AND_INS,
  input  wire logic        MASK_OR_INS,
  input  wire logic [15:0] MASK_OPERAND,
  input  wire logic        BIT13_SET_STB,
  input  wire logic        BIT13_CLR_STB,
  input  wire logic        EV_RADIO_IDLE,
  input  wire logic        EV_FRAME_SENT,
  input  wire logic        EV_ACK_SENT,
  input  wire logic        EV_TX_OVERFLOW,
  input  wire logic        EV_RX_UNDERFLOW,
  input  wire logic        EV_RX_OVERFLOW,
  input  wire logic        ACK_PEND_FSM,
  input  wire logic        TX_START,
  input  wire logic [6:0]  TX_LEN,
  input  wire logic        TX_BYTE_REQ,
  input  wire logic        TX_FIFO_EMPTY,
  input  wire logic [7:0]  TX_FIFO_DATA,
  output var  logic [7:0]  REG_RDATA,
  output var  logic [15:0] MASK,
  output var  logic [7:0]  EXC_FLAGS,
  output var  logic        RX_AUTO_ON,
  output var  logic        ACK_PEND,
  output var  logic [7:0]  TX_BYTE,
  output var  logic        TX_BYTE_VALID,
  output var  logic        TX_POP,
  output var  logic        TX_ABORT,
  output var  logic        TX_DONE
);

  // ------------------------------------------------------------
  // byte access decode
  // ------------------------------------------------------------
  // returns {write enables, write values} for one register byte;
  // a register write to the same byte wins over a bit instruction
  function automatic logic [15:0] byte_access(
    input logic [11:0] ofs,
    input logic        wr,
    input logic [11:0] wa,
    input logic [7:0]  wd,
    input logic        bs,
    input logic        bc,
    input logic [11:0] ba,
    input logic [2:0]  bi
  );
    logic [7:0] one;
    one = 8'h01 << bi;
    if (wr && wa == ofs)
      return {8'hff, wd};
    if ((bs || bc) && ba == ofs)
      return {one, bs ? one : 8'h00};
    return 16'h0000;
  endfunction

  function automatic logic [7:0] apply_byte(
    input logic [7:0]  old,
    input logic [15:0] acc
  );
    return (old & ~acc[15:8]) | (acc[7:0] & acc[15:8]);
  endfunction

  rxen_pkg::top_state_t st_r, st_nxt;

  logic [15:0] fc_acc;
  logic [15:0] lo_acc;
  logic [15:0] hi_acc;
  logic        starve_ev;
  logic [7:0]  fc_byte;
  logic [7:0]  keep;
  logic [7:0]  evt;

  assign fc_acc = byte_access(`OFS_FRAME_CTRL, REG_WR, REG_ADDR, REG_WDATA, BIT_SET, BIT_CLR, BIT_ADDR, BIT_IDX);
  assign lo_acc = byte_access(`OFS_MASK_LO, REG_WR, REG_ADDR, REG_WDATA, BIT_SET, BIT_CLR, BIT_ADDR, BIT_IDX);
  assign hi_acc = byte_access(`OFS_MASK_HI, REG_WR, REG_ADDR, REG_WDATA, BIT_SET, BIT_CLR, BIT_ADDR, BIT_IDX);

  // ------------------------------------------------------------
  // mask merge
  // ------------------------------------------------------------
  mask_upd_if mu ();

  assign mu.rf_off = RF_OFF_STB;
  assign mu.tx_on = TX_ON_STB;
  assign mu.tx_sets = st_r.fc.tx_sets;
  assign mu.rx_on = RX_ON_STB;
  assign mu.m_or = MASK_OR_INS;
  assign mu.m_and = MASK_AND_INS;
  assign mu.b13_set = BIT13_SET_STB;
  assign mu.b13_clr = BIT13_CLR_STB;
  assign mu.operand = MASK_OPERAND;
  assign mu.bus_we = {hi_acc[15:8], lo_acc[15:8]};
  assign mu.bus_val = {hi_acc[7:0], lo_acc[7:0]};
  assign mu.cur = st_r.mask;

  mask_merge u_merge (
    .mu (mu)
  );

  // ------------------------------------------------------------
  // transmit byte pump
  // ------------------------------------------------------------
  tx_starve u_tx (
    .clk        (CLK_SYS),
    .rst        (RST),
    .ce         (CE),
    .start      (TX_START),
    .len        (TX_LEN),
    .byte_req   (TX_BYTE_REQ),
    .fifo_empty (TX_FIFO_EMPTY),
    .fifo_byte  (TX_FIFO_DATA),
    .ignore     (st_r.fc.starve_ign),
    .out_byte   (TX_BYTE),
    .out_valid  (TX_BYTE_VALID),
    .pop        (TX_POP),
    .starve     (starve_ev),
    .abort      (TX_ABORT),
    .done       (TX_DONE)
  );

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    fc_byte = apply_byte({5'h00, st_r.fc}, fc_acc);
    st_nxt.fc = fc_byte[2:0];
    st_nxt.mask = mu.nxt;
    evt = {(st_r.mask != 16'h0000) && (mu.nxt == 16'h0000),
           EV_RX_OVERFLOW, EV_RX_UNDERFLOW, EV_TX_OVERFLOW,
           starve_ev, EV_ACK_SENT, EV_FRAME_SENT, EV_RADIO_IDLE};
    keep = st_r.flags;
    // writing a one leaves a flag alone; only zeros clear
    if (REG_WR && REG_ADDR == `OFS_EXC_LO)
      keep = keep & REG_WDATA;
    else if (BIT_CLR && BIT_ADDR == `OFS_EXC_LO)
      keep[BIT_IDX] = 1'b0;
    // a new event in the clearing cycle survives
    st_nxt.flags = keep | evt;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `OFS_FRAME_CTRL: st_nxt.rdata = {5'h00, st_r.fc};
        `OFS_MASK_LO:    st_nxt.rdata = st_r.mask[7:0];
        `OFS_MASK_HI:    st_nxt.rdata = st_r.mask[15:8];
        `OFS_EXC_LO:     st_nxt.rdata = st_r.flags;
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.ack_pend = st_r.fc.pend_ovr | ACK_PEND_FSM;
    st_nxt.rx_auto_on = (mu.nxt != 16'h0000);
    // clock enable low freezes everything, events included
    if (!CE)
      st_nxt = st_r;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st_r <= '0;
      st_r.fc <= `FRAME_CTRL_RESET;
      st_r.mask <= `MASK_RESET;
      st_r.flags <= `EXC_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign REG_RDATA = st_r.rdata;
  assign MASK = st_r.mask;
  assign EXC_FLAGS = st_r.flags;
  assign RX_AUTO_ON = st_r.rx_auto_on;
  assign ACK_PEND = st_r.ack_pend;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  logic bus_touch;
  logic upper_src;
  assign bus_touch = (mu.bus_we != 16'h0000);
  assign upper_src = RF_OFF_STB | TX_ON_STB | RX_ON_STB | bus_touch;

  // the AND instruction works on the mask after both bit-13 strobes,
  // so its expected result starts from that value, not from MASK
  logic [15:0] and_in;
  always_comb
  begin
    and_in = st_r.mask;
    if (BIT13_CLR_STB)
      and_in[`MASK_BIT_STB13] = 1'b0;
    if (BIT13_SET_STB)
      and_in[`MASK_BIT_STB13] = 1'b1;
  end

  // event pins and flag positions gathered apart from evt,
  // so a swapped bit in the flag byte shows up
  logic [5:0] ev_in;
  logic [5:0] ev_seen;
  assign ev_in = {EV_RX_OVERFLOW, EV_RX_UNDERFLOW, EV_TX_OVERFLOW, EV_ACK_SENT, EV_FRAME_SENT, EV_RADIO_IDLE};
  assign ev_seen = {EXC_FLAGS[`EXC_RX_OVER], EXC_FLAGS[`EXC_RX_UNDER], EXC_FLAGS[`EXC_TX_OVER],
                    EXC_FLAGS[`EXC_ACK_SENT], EXC_FLAGS[`EXC_FRAME_SENT], EXC_FLAGS[`EXC_RADIO_IDLE]};

  property p_ack_pend;
    (CE && st_r.fc.pend_ovr) |=> ACK_PEND;
  endproperty
  a_ack_pend: assert property (p_ack_pend) else $error("ack pending not forced");

  property p_rx_auto;
    RX_AUTO_ON == (MASK != 16'h0000);
  endproperty
  a_rx_auto: assert property (p_rx_auto) else $error("receiver enable disagrees with mask");

  property p_rx_on;
    (CE && RX_ON_STB && !RF_OFF_STB && !mu.bus_we[`MASK_BIT_RX_ON]) |=> MASK[`MASK_BIT_RX_ON];
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receive strobe missed bit 15");

  property p_tx_on;
    (CE && TX_ON_STB && st_r.fc.tx_sets && !RF_OFF_STB && !mu.bus_we[`MASK_BIT_TX_ON]) |=> MASK[`MASK_BIT_TX_ON];
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmit strobe missed bit 14");

  property p_tx_keep;
    (CE && TX_ON_STB && !st_r.fc.tx_sets && !RF_OFF_STB && !RX_ON_STB && !MASK_OR_INS && !MASK_AND_INS
     && !BIT13_SET_STB && !BIT13_CLR_STB && !bus_touch) |=> MASK == $past(MASK);
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("transmit strobe changed mask");

  property p_rf_off;
    (CE && RF_OFF_STB && !bus_touch) |=> MASK == 16'h0000;
  endproperty
  a_rf_off: assert property (p_rf_off) else $error("radio off left mask bits");

  property p_and;
    (CE && MASK_AND_INS && !MASK_OR_INS && !upper_src) |=> MASK == ($past(and_in) & $past(MASK_OPERAND));
  endproperty
  a_and: assert property (p_and) else $error("mask and result wrong");

  property p_or;
    (CE && MASK_OR_INS && !upper_src) |=> (MASK & $past(MASK_OPERAND)) == $past(MASK_OPERAND);
  endproperty
  a_or: assert property (p_or) else $error("mask or result wrong");

  property p_b13;
    (CE && BIT13_SET_STB && !MASK_AND_INS && !upper_src) |=> MASK[`MASK_BIT_STB13];
  endproperty
  a_b13: assert property (p_b13) else $error("bit 13 set strobe lost");

  property p_bus_wins;
    (CE && REG_WR && REG_ADDR == `OFS_MASK_LO) |=> MASK[7:0] == $past(REG_WDATA);
  endproperty
  a_bus_wins: assert property (p_bus_wins) else $error("bus write did not win");

  property p_sticky;
    (CE && !(REG_WR && REG_ADDR == `OFS_EXC_LO) && !(BIT_CLR && BIT_ADDR == `OFS_EXC_LO))
      |=> (EXC_FLAGS & $past(EXC_FLAGS)) == $past(EXC_FLAGS);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_write_zero;
    (CE && REG_WR && REG_ADDR == `OFS_EXC_LO)
      |=> (EXC_FLAGS & ~($past(EXC_FLAGS & REG_WDATA) | $past(evt))) == 8'h00;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write of one set a flag");

  property p_zero_flag;
    (CE && MASK != 16'h0000 && mu.nxt == 16'h0000) |=> EXC_FLAGS[`EXC_MASK_ZERO];
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("mask zero flag not raised");

  property p_resv;
    (CE && REG_RD && REG_ADDR == `OFS_FRAME_CTRL) |=> REG_RDATA[7:3] == 5'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");

  property p_starve_flag;
    (CE && starve_ev) |=> EXC_FLAGS[`EXC_TX_UNDER];
  endproperty
  a_starve_flag: assert property (p_starve_flag) else $error("underflow flag missing");

  property p_b13_clr;
    (CE && BIT13_CLR_STB && !BIT13_SET_STB && !MASK_OR_INS && !upper_src) |=> !MASK[`MASK_BIT_STB13];
  endproperty
  a_b13_clr: assert property (p_b13_clr) else $error("bit 13 clear strobe lost");

  property p_bit_set;
    (CE && BIT_SET && BIT_ADDR == `OFS_MASK_HI && !(REG_WR && REG_ADDR == `OFS_MASK_HI))
      |=> (MASK[15:8] & (8'h01 << $past(BIT_IDX))) != 8'h00;
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set missed mask bit");

  property p_flag_pos;
    CE |=> (ev_seen & $past(ev_in)) == $past(ev_in);
  endproperty
  a_flag_pos: assert property (p_flag_pos) else $error("event flag not raised");

  c_rf_off: cover property (CE && RF_OFF_STB && MASK != 16'h0000);
  c_conflict: cover property (CE && RX_ON_STB && MASK_AND_INS && BIT13_SET_STB);
  c_flag_clear: cover property (CE && REG_WR && REG_ADDR == `OFS_EXC_LO && EXC_FLAGS != 8'h00);

endmodule // rx_enable_ctrl

`default_nettype wire

// ### host_cmd_model.sv
/*
  Host side of the serial command port: issues register writes,
  reads and bit instructions to the mask and flag registers.
  Assumes calls are made just after a rising edge of clk.
*/
`default_nettype none

module host_cmd_model (
  input  wire logic        clk,
  input  wire logic [7:0]  rdata,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [11:0] addr,
  output var  logic [7:0]  wdata,
  output var  logic        bit_set_instruction,
  output var  logic        bit_clear_instruction,
  output var  logic [11:0] baddr,
  output var  logic [2:0]  bidx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {wr, rd, addr, wdata, bit_set_instruction, bit_clear_instruction, baddr, bidx} = '0;
  end

  // op: 1 write, 3 bit set, 4 bit clear, others idle
  task automatic put(input logic [2:0] op, input logic [11:0] a, input logic [7:0] d, input logic [2:0] i);
    wr    <= (op == 3'h1);
    rd    <= 1'b0;
    bit_set_instruction  <= (op == 3'h3);
    bit_clear_instruction  <= (op == 3'h4);
    // idle lines keep moving so a stale value is never mistaken for a command
    addr  <= (op == 3'h0) ? ~addr : a;
    baddr <= (op == 3'h0) ? ~baddr : a;
    wdata <= (op == 3'h0) ? ~wdata : d;
    bidx  <= i;
  endtask

  task automatic read(input logic [11:0] a, output logic [7:0] d);
    {wr, bit_set_instruction, bit_clear_instruction} <= 3'h0;
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule  // host_cmd_model

`default_nettype wire

// ### rx_enable_mask_and_exception_flags_tb_top.sv
/*
  Self-checking bench: random mask, flag and control traffic against
  a bench model, plus transmit pump frames with starvation.
  Assumes host_cmd_model for register commands.
*/
`default_nettype none
`include "rxen_map.svh"

module rx_enable_mask_and_exception_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, ce, wr, rd, bs, bc, txs, rxs, rfo, mand, mor, s13, c13, fsm;
  logic        tst, treq, temp, tval, tpop, tab, tdone, aon, apend, ap;
  logic [11:0] addr, baddr;
  logic [7:0]  wd, rdat, tfd, tbyte, exc, f, c;
  logic [2:0]  bidx;
  logic [5:0]  ev;
  logic [6:0]  tlen;
  logic [15:0] opd, mask, m, nm;
  logic [31:0] r;
  logic [11:0] amap [8] = '{12'h00d, 12'h00e, 12'h00f, 12'h010, 12'h011, 12'h00e, 12'h00f, 12'h00e};
  integer      seed = 90;
  integer      fails = 0;
  integer      num_checks = 0;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  host_cmd_model u_host (.clk(clk), .rdata(rdat), .wr(wr), .rd(rd), .addr(addr), .wdata(wd),
                         .bit_set_instruction(bs), .bit_clear_instruction(bc), .baddr(baddr), .bidx(bidx));

  rx_enable_ctrl u_dut (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd),
    .BIT_SET(bs), .BIT_CLR(bc), .BIT_ADDR(baddr), .BIT_IDX(bidx), .TX_ON_STB(txs), .RX_ON_STB(rxs),
    .RF_OFF_STB(rfo), .MASK_AND_INS(mand), .MASK_OR_INS(mor), .MASK_OPERAND(opd),
    .BIT13_SET_STB(s13), .BIT13_CLR_STB(c13), .EV_RADIO_IDLE(ev[0]), .EV_FRAME_SENT(ev[1]),
    .EV_ACK_SENT(ev[2]), .EV_TX_OVERFLOW(ev[3]), .EV_RX_UNDERFLOW(ev[4]), .EV_RX_OVERFLOW(ev[5]),
    .ACK_PEND_FSM(fsm), .TX_START(tst), .TX_LEN(tlen), .TX_BYTE_REQ(treq), .TX_FIFO_EMPTY(temp),
    .TX_FIFO_DATA(tfd), .REG_RDATA(rdat), .MASK(mask), .EXC_FLAGS(exc), .RX_AUTO_ON(aon),
    .ACK_PEND(apend), .TX_BYTE(tbyte), .TX_BYTE_VALID(tval), .TX_POP(tpop), .TX_ABORT(tab),
    .TX_DONE(tdone)
  );

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.read(a, d);
    chk("REG_RDATA", e, d);
    @(posedge clk);
  endtask

  // one frame; byte number stv finds the buffer empty
  task automatic tx_run(input logic ign, input int len, input int stv);
    logic hit;
    logic st;
    hit = 1'b0;
    @(posedge clk);
    u_host.put(3'h1, 12'h00d, {6'h00, ign, 1'b1}, 3'h0);
    @(posedge clk);
    u_host.put(3'h0, 12'h000, 8'h00, 3'h0);
    tst  <= 1'b1;
    tlen <= len[6:0];
    @(posedge clk);
    tst <= 1'b0;
    #1;
    chk("TX_DONE", len == 0, tdone);
    for (int k = 0; k < len; k++)
    begin
      @(posedge clk);
      r = $random(seed);
      treq <= 1'b1;
      temp <= (k == stv);
      tfd  <= r[7:0];
      @(posedge clk);
      treq <= 1'b0;
      temp <= 1'b0;
      #1;
      st  = (k == stv);
      hit = hit | st;
      chk("TX_ABORT", st && !ign, tab);
      chk("TX_BYTE_VALID", !(st && !ign), tval);
      chk("TX_POP", !st, tpop);
      chk("TX_DONE", (k == len - 1) && !(st && !ign), tdone);
      if (st && !ign)
        break;
      chk("TX_BYTE", st ? `TX_FILL_BYTE : tfd, tbyte);
    end
    @(posedge clk);
    #1;
    chk("EXC_FLAGS", hit, exc[3]);
    @(posedge clk);
    u_host.put(3'h1, 12'h010, 8'h00, 3'h0);
    @(posedge clk);
    u_host.put(3'h0, 12'h000, 8'h00, 3'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {txs, rxs, rfo, mand, mor, s13, c13, fsm, tst, treq, temp, ev, opd, tfd, tlen} = '0;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 12; a < 18; a++)
      rchk(a[11:0] + 12'h001, (a == 12) ? 8'h01 : 8'h00);
    tx_run(1'b0, 3, 1);
    tx_run(1'b1, 3, 1);
    tx_run(1'b0, 2, 9);
    tx_run(1'b0, 0, 9);
    m = 16'h0000;
    f = 8'h00;
    c = 8'h01;
    ap = 1'b0;
    // the last two passes drive an idle cycle so the model settles
    for (int n = 0; n < 602; n++)
    begin
      @(posedge clk);
      r = (n < 600) ? $random(seed) : 32'h0000_0003;
      ce   <= r[0] | r[1];
      rfo  <= &r[4:2];
      {txs, rxs, mor, mand, s13, c13, fsm} <= r[11:5];
      ev   <= r[17:12] & r[23:18] & r[29:24];
      r = (n < 600) ? $random(seed) : 32'h0000_0000;
      opd  <= r[15:0];
      u_host.put(r[18:16], amap[r[21:19]], r[29:22], {r[31:30], r[0]});
      #1;
      chk("MASK", m, mask);
      chk("RX_AUTO_ON", |m, aon);
      chk("EXC_FLAGS", f, exc);
      chk("ACK_PEND", ap, apend);
      if (ce)
      begin
        ap = c[2] | fsm;
        nm = m;
        if (c13) nm[13] = 1'b0;
        if (s13) nm[13] = 1'b1;
        if (mand) nm = nm & opd;
        if (mor) nm = nm | opd;
        if (rxs) nm[15] = 1'b1;
        if (txs && c[0]) nm[14] = 1'b1;
        if (rfo) nm = 16'h0000;
        if ((bs || bc) && baddr == 12'h00e) nm[bidx] = bs;
        if ((bs || bc) && baddr == 12'h00f) nm[{1'b1, bidx}] = bs;
        if (bc && baddr == 12'h010) f[bidx] = 1'b0;
        if ((bs || bc) && baddr == 12'h00d && bidx < 3) c[bidx] = bs;
        if (wr && addr == 12'h00e) nm[7:0] = wd;
        if (wr && addr == 12'h00f) nm[15:8] = wd;
        if (wr && addr == 12'h010) f = f & wd;
        if (wr && addr == 12'h00d) c = {5'h00, wd[2:0]};
        f = f | {1'b0, ev[5:3], 1'b0, ev[2:0]};
        if (m != 16'h0000 && nm == 16'h0000) f[7] = 1'b1;
        m = nm;
      end
    end
    @(posedge clk);
    rchk(12'h00d, c);
    rchk(12'h00e, m[7:0]);
    rchk(12'h00f, m[15:8]);
    rchk(12'h010, f);
    finish_test();
  end

  initial
  begin
    #200us;
    fails++;
    finish_test();
  end
endmodule  // rx_enable_mask_and_exception_flags_tb_top

`default_nettype wire
